/* File: tof_ctrl_params.svh */
// Offsets, field positions and reset values of the top control register bank
`ifndef TOF_CTRL_PARAMS_SVH
`define TOF_CTRL_PARAMS_SVH
`define TOP_CONTROL_ADDR 8'h00
`define AMB_PHASE_COEFFS_ADDR 8'hB4
`define AMB_BREAKPOINTS_A_ADDR 8'hB8
`define ILLUM_SCALE_BP_ADDR 8'hB9
`define ONESHOT_POS 23
`define FORCE_ACCESS_POS 22
`define BYPASS_POS 21
`define CONT_ACCESS_POS 6
`define SOFT_RESET_POS 0
`define TOP_CONTROL_RESET 24'h000000
`define AUX_REG_RESET 24'h000000
`define TOP_CONTROL_WMASK 24'hE00041
`endif

/* File: tof_ctrl_pkg.sv */
// Types for the top control register bank
package tof_ctrl_pkg;
    typedef enum logic [1:0] {
        CAPT_IDLE = 2'b00,
        CAPT_RUN = 2'b01,
        CAPT_DONE = 2'b11
    } capture_state_t;
endpackage

/* File: top_control_register.sv */
// Top control register bank of the ranging front end
//
// Function
// - Writing one-shot bit starts single capture
// - One-shot bit self-clears when capture finishes
// - Forced-access bit lets internal host reach registers
// - Bypass disables internal host, joins buses
// - Continuous-access bit enables multi-register transfers
// - Soft reset bit restores all defaults
// - Reserved bits read zero, written zero
`timescale 1ns/100ps
`include "tof_ctrl_params.svh"

module top_control_register
    import tof_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 24
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    // Register port from the slave interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Capture engine
    input wire logic capture_done,
    output logic capture_start,
    output logic capture_busy,
    // Controls to the I2C paths
    output logic forced_access,
    output logic host_bypass,
    output logic internal_host_en,
    output logic continuous_access_enable,
    output logic device_reset
);

    logic oneshot_reg;
    logic force_reg;
    logic bypass_reg;
    logic cont_reg;
    logic soft_reset_reg;
    logic [DATA_W-1:0] coeff_reg;
    logic [DATA_W-1:0] bp_a_reg;
    logic [DATA_W-1:0] illum_reg;
    logic [DATA_W-1:0] rdata_next;
    capture_state_t capt_reg;
    logic ctrl_wr;
    logic rst_all;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a == b;
    endfunction

    // Trigger is accepted when no capture is running
    function automatic logic trigger_ok(input capture_state_t s);
        return (s == CAPT_IDLE) || (s == CAPT_DONE);
    endfunction

    assign ctrl_wr = reg_wr && hit(reg_addr, ADDR_W'(`TOP_CONTROL_ADDR));
    // Soft reset pulse acts one cycle after the write
    assign rst_all = srst || (clk_en && soft_reset_reg);

    // Soft reset bit: set by write, clears itself on the next enabled cycle, when its reset acts
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_reg <= 1'b0;
        end else if (clk_en) begin
            soft_reset_reg <= ctrl_wr && reg_wdata[`SOFT_RESET_POS] && !soft_reset_reg;
        end
    end

    // Settings bits
    always_ff @(posedge clk) begin
        if (rst_all) begin
            force_reg <= 1'b0;
            bypass_reg <= 1'b0;
            cont_reg <= 1'b0;
        end else if (clk_en && ctrl_wr) begin
            force_reg <= reg_wdata[`FORCE_ACCESS_POS];
            bypass_reg <= reg_wdata[`BYPASS_POS];
            cont_reg <= reg_wdata[`CONT_ACCESS_POS];
        end
    end

    // One-shot capture sequencing
    always_ff @(posedge clk) begin
        if (rst_all) begin
            capt_reg <= CAPT_IDLE;
            oneshot_reg <= 1'b0;
        end else if (clk_en) begin
            case (capt_reg)
                // A trigger right after completion starts the next capture
                CAPT_IDLE, CAPT_DONE: begin
                    if (ctrl_wr && reg_wdata[`ONESHOT_POS]) begin
                        oneshot_reg <= 1'b1;
                        capt_reg <= CAPT_RUN;
                    end else begin
                        capt_reg <= CAPT_IDLE;
                    end
                end
                CAPT_RUN: begin
                    if (capture_done) begin
                        oneshot_reg <= 1'b0;
                        capt_reg <= CAPT_DONE;
                    end
                end
                default: begin
                    capt_reg <= CAPT_IDLE;
                    oneshot_reg <= 1'b0;
                end
            endcase
        end
    end

    // Coefficient and breakpoint registers
    always_ff @(posedge clk) begin
        if (rst_all) begin
            coeff_reg <= `AUX_REG_RESET;
            bp_a_reg <= `AUX_REG_RESET;
            illum_reg <= `AUX_REG_RESET;
        end else if (clk_en && reg_wr) begin
            if (hit(reg_addr, ADDR_W'(`AMB_PHASE_COEFFS_ADDR))) begin
                coeff_reg <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_W'(`AMB_BREAKPOINTS_A_ADDR))) begin
                bp_a_reg <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_W'(`ILLUM_SCALE_BP_ADDR))) begin
                illum_reg <= reg_wdata;
            end
        end
    end

    // Read mux; reserved control bits read zero
    always_comb begin
        rdata_next = '0;
        if (hit(reg_addr, ADDR_W'(`TOP_CONTROL_ADDR))) begin
            rdata_next[`ONESHOT_POS] = oneshot_reg;
            rdata_next[`FORCE_ACCESS_POS] = force_reg;
            rdata_next[`BYPASS_POS] = bypass_reg;
            rdata_next[`CONT_ACCESS_POS] = cont_reg;
            rdata_next[`SOFT_RESET_POS] = soft_reset_reg;
        end else if (hit(reg_addr, ADDR_W'(`AMB_PHASE_COEFFS_ADDR))) begin
            rdata_next = coeff_reg;
        end else if (hit(reg_addr, ADDR_W'(`AMB_BREAKPOINTS_A_ADDR))) begin
            rdata_next = bp_a_reg;
        end else if (hit(reg_addr, ADDR_W'(`ILLUM_SCALE_BP_ADDR))) begin
            rdata_next = illum_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    assign capture_start = clk_en && ctrl_wr && reg_wdata[`ONESHOT_POS]
        && trigger_ok(capt_reg);
    assign capture_busy = oneshot_reg;
    assign forced_access = force_reg;
    assign host_bypass = bypass_reg;
    assign internal_host_en = !bypass_reg;
    assign continuous_access_enable = cont_reg;
    assign device_reset = soft_reset_reg;

    a_oneshot_set: assert property (@(posedge clk) disable iff (rst_all)
        capture_start |=> oneshot_reg)
        else $error("one-shot bit not set after trigger");
    a_no_retrigger: assert property (@(posedge clk) disable iff (srst)
        capture_busy |-> !capture_start)
        else $error("capture restarted while busy");
    a_oneshot_clear: assert property (@(posedge clk) disable iff (rst_all)
        (clk_en && oneshot_reg && capture_done) |=> !oneshot_reg)
        else $error("one-shot bit not cleared after capture");
    a_busy_holds: assert property (@(posedge clk) disable iff (rst_all)
        (capture_busy && !capture_done) |=> capture_busy)
        else $error("one-shot bit cleared before capture end");
    a_force_follow: assert property (@(posedge clk) disable iff (rst_all)
        (clk_en && ctrl_wr) |=> forced_access == $past(reg_wdata[`FORCE_ACCESS_POS]))
        else $error("forced access does not follow write");
    a_bypass_host: assert property (@(posedge clk) host_bypass |-> !internal_host_en)
        else $error("internal host active in bypass");
    a_bypass_follow: assert property (@(posedge clk) disable iff (rst_all)
        (clk_en && ctrl_wr) |=> host_bypass == $past(reg_wdata[`BYPASS_POS]))
        else $error("bypass does not follow write");
    a_cont_follow: assert property (@(posedge clk) disable iff (rst_all)
        (clk_en && ctrl_wr)
        |=> continuous_access_enable == $past(reg_wdata[`CONT_ACCESS_POS]))
        else $error("continuous access does not follow write");
    a_soft_reset: assert property (@(posedge clk) disable iff (srst)
        (clk_en && device_reset) |=> (!device_reset && !forced_access && !host_bypass
            && !capture_busy && !continuous_access_enable))
        else $error("soft reset did not restore defaults");
    a_soft_reset_take: assert property (@(posedge clk) disable iff (srst)
        (clk_en && ctrl_wr && reg_wdata[`SOFT_RESET_POS] && !device_reset)
        |=> device_reset)
        else $error("soft reset write ignored");
    a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
        (reg_rvalid && $past(clk_en && reg_rd && hit(reg_addr, ADDR_W'(`TOP_CONTROL_ADDR))))
        |-> (reg_rdata & ~DATA_W'(`TOP_CONTROL_WMASK)) == '0)
        else $error("reserved control bits not zero");
    a_freeze_state: assert property (@(posedge clk) disable iff (srst)
        !clk_en |=> $stable({capture_busy, forced_access, host_bypass,
            continuous_access_enable, device_reset, reg_rvalid}))
        else $error("state changed while clock enable low");
    a_read_valid: assert property (@(posedge clk) disable iff (srst)
        (clk_en && reg_rd) |=> reg_rvalid)
        else $error("read not answered");

endmodule // top_control_register

/* File: capture_engine_model.sv */
// Capture engine stand-in answering each start with a done pulse
`timescale 1ns/100ps
module capture_engine_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Capture handshake
    input wire logic capture_start,
    output logic capture_done
);
    int cnt;
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 0;
            capture_done <= 1'b0;
        end else begin
            capture_done <= (cnt == 1);
            if (capture_start) begin
                cnt <= DELAY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // capture_engine_model

/* File: tb.sv */
// Self-checking bench for the top control register bank
`timescale 1ns/100ps
`include "tof_ctrl_params.svh"
module tb;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, en = 1, done;
    logic [7:0] addr = 8'h00;
    logic [23:0] wdata = 24'h000000, rdata;
    logic rvalid, start, busy, fa, byp, ihe, cae, dres;
    int err_count = 0, check_count = 0, cyc = 0;
    top_control_register top_control_register_inst (.clk(clk), .srst(srst), .clk_en(en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .capture_done(done),
        .capture_start(start), .capture_busy(busy), .forced_access(fa),
        .host_bypass(byp), .internal_host_en(ihe), .continuous_access_enable(cae),
        .device_reset(dres));
    capture_engine_model capture_engine_model_inst (.clk(clk), .srst(srst),
        .capture_start(start), .capture_done(done));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk);
        reg_wr = 1;
        addr = a;
        wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(negedge clk);
        reg_rd = 1;
        addr = a;
        @(negedge clk);
        reg_rd = 0;
        chk("rvalid", {23'h0, rvalid}, 24'h000001);
        chk("rdata", rdata, e);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        srst = 0;
        rd(`TOP_CONTROL_ADDR, 24'h000000);
        chk("ihe", {23'h0, ihe}, 24'h000001);
        // Set forced access, bypass and continuous access and read them back
        wr(`TOP_CONTROL_ADDR, 24'h600040);
        rd(`TOP_CONTROL_ADDR, 24'h600040);
        chk("fa", {23'h0, fa}, 24'h000001);
        chk("byp", {22'h0, byp, ihe}, 24'h000002);
        chk("cae", {23'h0, cae}, 24'h000001);
        wr(`AMB_PHASE_COEFFS_ADDR, 24'hA5A5A5);
        wr(`AMB_BREAKPOINTS_A_ADDR, 24'h1C3E5F);
        wr(`ILLUM_SCALE_BP_ADDR, 24'hE2C1A0);
        wr(8'h01, 24'h123456);
        rd(`AMB_PHASE_COEFFS_ADDR, 24'hA5A5A5);
        rd(`AMB_BREAKPOINTS_A_ADDR, 24'h1C3E5F);
        rd(`ILLUM_SCALE_BP_ADDR, 24'hE2C1A0);
        rd(8'h01, 24'h000000);
        // Writes are not taken while the clock enable is low
        @(negedge clk);
        en = 0;
        reg_wr = 1;
        addr = `AMB_PHASE_COEFFS_ADDR;
        wdata = 24'h5A5A5A;
        @(negedge clk);
        reg_wr = 0;
        en = 1;
        rd(`AMB_PHASE_COEFFS_ADDR, 24'hA5A5A5);
        @(negedge clk);
        reg_wr = 1;
        addr = `TOP_CONTROL_ADDR;
        wdata = 24'h800000;
        #1 chk("start", {23'h0, start}, 24'h000001);
        @(negedge clk);
        reg_wr = 0;
        chk("busy", {23'h0, busy}, 24'h000001);
        rd(`TOP_CONTROL_ADDR, 24'h800000);
        // A second trigger during the capture is refused
        @(negedge clk);
        reg_wr = 1;
        #1 chk("start", {23'h0, start}, 24'h000000);
        @(negedge clk);
        reg_wr = 0;
        chk("busy", {23'h0, busy}, 24'h000001);
        for (int i = 0; i < 20 && busy === 1'b1; i++) begin
            @(negedge clk);
        end
        chk("busy", {23'h0, busy}, 24'h000000);
        // Trigger in the cycle right after completion
        reg_wr = 1;
        #1 chk("start", {23'h0, start}, 24'h000001);
        @(negedge clk);
        reg_wr = 0;
        for (int i = 0; i < 20 && busy === 1'b1; i++) begin
            @(negedge clk);
        end
        rd(`TOP_CONTROL_ADDR, 24'h000000);
        wr(`TOP_CONTROL_ADDR, 24'h400041);
        chk("dres", {23'h0, dres}, 24'h000001);
        chk("fa", {23'h0, fa}, 24'h000001);
        @(negedge clk);
        chk("dres", {23'h0, dres}, 24'h000000);
        rd(`TOP_CONTROL_ADDR, 24'h000000);
        rd(`AMB_PHASE_COEFFS_ADDR, 24'h000000);
        chk("fa", {23'h0, fa}, 24'h000000);
        // Mid-run reset drops the bypass
        wr(`TOP_CONTROL_ADDR, 24'h200000);
        chk("ihe", {23'h0, ihe}, 24'h000000);
        srst = 1;
        repeat (2) @(negedge clk);
        srst = 0;
        chk("byp", {22'h0, byp, ihe}, 24'h000001);
        results();
    end
endmodule // tb
